/* logic/see_host_end.sv */
// Host end: two-wire master issuing byte writes and random reads
module see_host_end #(
    parameter int QTR_CYC = see_pkg::SCL_QTR_CYC,
    parameter int RBUF_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    see_bus_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [see_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_len,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    output logic done,
    output logic nack
);
    import see_pkg::*;

    localparam int DW = $clog2(QTR_CYC);
    localparam int PW = (RBUF_DEPTH > 1) ? $clog2(RBUF_DEPTH) : 1;

    // Parameter check
    if (QTR_CYC < SCL_QTR_CYC || RBUF_DEPTH != 2) begin : g_bad_param
        $error("see_host_end: bad parameters");
    end

    see_host_st_t st_q;
    see_step_t step_q;
    logic [1:0] ph_q;
    logic [DW-1:0] div_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic rx_q;
    logic nak_q;
    logic [7:0] rem_q;
    logic rd_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] wdata_q;
    logic scl_q;
    logic oe_q;
    logic done_q;
    logic nack_q;
    logic [1:0] sda_s_q;
    logic tick;
    logic stall;
    logic push;
    logic [7:0] buf_q [RBUF_DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rdp_q;
    logic [PW:0] cnt_q;

    // Byte sent for a given step
    function automatic logic [7:0] step_byte(input see_step_t s, input logic [ADDR_W-1:0] a,
                                             input logic [7:0] d);
        logic [7:0] b;
        b = BYTE_RST;
        unique case (s)
            S_DEVW: b = {TYPE_CODE, a[10:8], 1'b0};
            S_AHI: b = {5'h00, a[10:8]};
            S_ALO: b = a[7:0];
            S_DATA: b = d;
            S_DEVR: b = {TYPE_CODE, a[10:8], 1'b1};
            S_RD: b = BYTE_RST;
        endcase
        return b;
    endfunction

    // Line drive and handshakes
    assign bus.scl = scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = oe_q;
    assign cmd_ready = (st_q == M_IDLE);
    assign done = done_q;
    assign nack = nack_q;
    assign rd_valid = (cnt_q != '0);
    assign rd_data = buf_q[rdp_q];

    // Stretch SCL while the read buffer is full
    assign stall = (st_q == M_XFER) && rx_q && (bit_q == BIT_ACK) && (ph_q == 2'h0)
                   && (cnt_q == (PW+1)'(RBUF_DEPTH));
    assign tick = (st_q != M_IDLE) && !stall && (div_q == DW'(QTR_CYC - 1));
    assign push = tick && (st_q == M_XFER) && rx_q && (bit_q == BIT_ACK) && (ph_q == 2'h0);

    // Data line synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sda_s_q <= 2'h3;
        end else begin
            sda_s_q <= {sda_s_q[0], bus.sda_line};
        end
    end

    // Quarter-bit divider
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (st_q == M_IDLE || stall || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Two-entry read buffer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rdp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (rd_valid && rd_ready) begin
                rdp_q <= rdp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(rd_valid && rd_ready);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) begin
            buf_q[wr_q] <= shift_q;
        end
    end

    // Bus sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= M_IDLE;
            step_q <= S_DEVW;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            shift_q <= BYTE_RST;
            rx_q <= 1'b0;
            nak_q <= 1'b0;
            rem_q <= 8'h00;
            rd_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= BYTE_RST;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            nack_q <= 1'b0;
            if (st_q == M_IDLE) begin
                if (cmd_valid) begin
                    st_q <= M_START;
                    step_q <= S_DEVW;
                    ph_q <= 2'h0;
                    rd_q <= cmd_read;
                    addr_q <= cmd_addr;
                    wdata_q <= cmd_wdata;
                    rem_q <= cmd_len;
                end
            end else if (tick) begin
                ph_q <= ph_q + 2'h1;
                unique case (st_q)
                    M_START: begin
                        scl_q <= (ph_q == 2'h1) || (ph_q == 2'h2);
                        oe_q <= (ph_q == 2'h2) || (ph_q == 2'h3);
                        if (ph_q == 2'h3) begin
                            st_q <= M_XFER;
                            bit_q <= 4'h0;
                            shift_q <= step_byte(step_q, addr_q, wdata_q);
                            rx_q <= (step_q == S_RD);
                        end
                    end
                    M_XFER: begin
                        scl_q <= (ph_q == 2'h1) || (ph_q == 2'h2);
                        if (ph_q == 2'h0) begin
                            // Data changes only with the clock low
                            if (bit_q == BIT_ACK) begin
                                oe_q <= rx_q && (rem_q != 8'h00);
                            end else begin
                                oe_q <= !rx_q && !shift_q[7];
                            end
                        end
                        if (ph_q == 2'h2) begin
                            if (bit_q < BIT_ACK) begin
                                shift_q <= {shift_q[6:0], sda_s_q[1]};
                            end else begin
                                nak_q <= !rx_q && sda_s_q[1];
                            end
                        end
                        if (ph_q == 2'h3) begin
                            if (bit_q < BIT_ACK) begin
                                bit_q <= bit_q + 4'h1;
                            end else begin
                                bit_q <= 4'h0;
                                oe_q <= 1'b0;
                                rx_q <= 1'b0;
                                if (nak_q) begin
                                    st_q <= M_STOP;
                                    nack_q <= 1'b1;
                                end else begin
                                    unique case (step_q)
                                        S_DEVW: step_q <= S_AHI;
                                        S_AHI: step_q <= S_ALO;
                                        S_ALO: begin
                                            step_q <= rd_q ? S_DEVR : S_DATA;
                                            if (rd_q) begin
                                                st_q <= M_START;
                                            end
                                        end
                                        S_DATA: st_q <= M_STOP;
                                        S_DEVR: step_q <= S_RD;
                                        S_RD: begin
                                            if (rem_q == 8'h00) begin
                                                st_q <= M_STOP;
                                            end
                                            rem_q <= rem_q - 8'h01;
                                        end
                                    endcase
                                    shift_q <= 8'hFF;
                                    rx_q <= (step_q == S_DEVR) || (step_q == S_RD);
                                    if (!rd_q && step_q == S_ALO) begin
                                        shift_q <= wdata_q;
                                    end else if (step_q == S_DEVW) begin
                                        shift_q <= step_byte(S_AHI, addr_q, wdata_q);
                                    end else if (step_q == S_AHI) begin
                                        shift_q <= step_byte(S_ALO, addr_q, wdata_q);
                                    end
                                end
                            end
                        end
                    end
                    M_STOP: begin
                        scl_q <= (ph_q != 2'h0);
                        oe_q <= (ph_q == 2'h0) || (ph_q == 2'h1);
                        if (ph_q == 2'h3) begin
                            st_q <= M_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                    default: begin
                        st_q <= M_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* logic/see_pkg.sv */
// Shared constants and state types for the two-wire EEPROM link ends
package see_pkg;
    // Clocks and the quarter-bit time of the bus clock
    localparam int CLK_HZ = 125_000_000;
    localparam int SCL_MAX_HZ = 400_000;
    localparam int SCL_QTR_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
    // Longest programming time in cycles
    localparam int PROG_TIME_MS = 5;
    localparam int PROG_CYC = (CLK_HZ / 1000) * PROG_TIME_MS;
    // Array size and address word layout
    localparam int MEM_BYTES = 2048;
    localparam int ADDR_W = 11;
    localparam logic [3:0] TYPE_CODE = 4'hA;
    localparam int TYPE_POS = 4;
    localparam int RW_POS = 0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Device end states
    typedef enum logic [6:0] {
        D_IDLE  = 7'b0000001,
        D_DEV   = 7'b0000010,
        D_ADRH  = 7'b0000100,
        D_ADRL  = 7'b0001000,
        D_WDATA = 7'b0010000,
        D_RDATA = 7'b0100000,
        D_PROG  = 7'b1000000
    } see_dev_st_t;

    // Host end bus states
    typedef enum logic [3:0] {
        M_IDLE  = 4'b0001,
        M_START = 4'b0010,
        M_XFER  = 4'b0100,
        M_STOP  = 4'b1000
    } see_host_st_t;

    // Host end byte steps
    typedef enum logic [5:0] {
        S_DEVW = 6'b000001,
        S_AHI  = 6'b000010,
        S_ALO  = 6'b000100,
        S_DATA = 6'b001000,
        S_DEVR = 6'b010000,
        S_RD   = 6'b100000
    } see_step_t;
endpackage

/* logic/see_bus_if.sv */
// Two-wire link between host end and device end
interface see_bus_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    wire sda_line;

    // Open-drain wired level with pull-up
    assign sda_line = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));

    modport host (output scl, output sda_m_o, output sda_m_oe, input sda_line);
    modport device (input scl, input sda_line, output sda_d_o, output sda_d_oe);
endinterface

/* logic/see_dev_end.sv */
// Device end: two-wire EEPROM slave with array and programming timer
//
// Overview of operation
// - Sample on SCL rise, change after fall
// - Master changes SDA only while SCL low
// - Drive SDA low or release only
// - Reads work regardless of write-protect
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - Stop after write data starts programming
// - Eight bits then ninth acknowledge clock
// - Acknowledge every received write byte low
// - Release after read byte; ack sends next
// - Master nack plus stop ends read
// - No ack, no stop: stay released
// - First word carries type code 1010
// - Address word bits supply high address
// - Last bit selects write or read
// - Match acknowledges, mismatch returns to standby
// - Byte write: word, two addresses, data
// - Ignore bus while programming runs
// - Master sends address word after start
// - Programming lasts at most five milliseconds
// - Write word unacknowledged while programming
module see_dev_end #(
    parameter int PROG_CYCLES = see_pkg::PROG_CYC,
    parameter int MEM_DEPTH = see_pkg::MEM_BYTES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    see_bus_if.device bus,
    input wire logic wp,
    output logic prog_busy
);
    import see_pkg::*;

    localparam int AW = $clog2(MEM_DEPTH);
    localparam int CW = $clog2(PROG_CYCLES);

    // Parameter check
    if (MEM_DEPTH < 512 || MEM_DEPTH > 2048 || (1 << AW) != MEM_DEPTH || PROG_CYCLES < 2)
    begin : g_bad_param
        $error("see_dev_end: bad parameters");
    end

    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [1:0] wp_s_q;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    see_dev_st_t st_q;
    see_dev_st_t nxt_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic oe_q;
    logic ack_q;
    logic acked_q;
    logic halt_q;
    logic pend_q;
    logic wp_lock_q;
    logic [AW-1:0] addr_q;
    logic [7:0] wdata_q;
    logic [CW-1:0] prog_cnt_q;
    logic prog_done;
    logic [7:0] mem_q [MEM_DEPTH];

    // Two-flop pin synchronisers plus edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            wp_s_q <= 2'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], bus.scl};
            sda_s_q <= {sda_s_q[0], bus.sda_line};
            wp_s_q <= {wp_s_q[0], wp};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    // Edge and condition detection
    assign scl_s = scl_s_q[1];
    assign sda_s = sda_s_q[1];
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // Open-drain: only ever pulls low
    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = oe_q;
    assign prog_busy = st_q[6];

    // Programming cycle timer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prog_cnt_q <= '0;
        end else if (st_q == D_PROG && !prog_done) begin
            prog_cnt_q <= prog_cnt_q + 1'b1;
        end else begin
            prog_cnt_q <= '0;
        end
    end
    assign prog_done = (st_q == D_PROG) && (prog_cnt_q == CW'(PROG_CYCLES - 1));

    // Array write after programming, refused in the protected half
    always_ff @(posedge clk_sys) begin
        if (prog_done && !(wp_lock_q && addr_q[AW-1])) begin
            mem_q[addr_q] <= wdata_q;
        end
    end

    // Protocol engine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= D_IDLE;
            nxt_q <= D_IDLE;
            bit_q <= 4'h0;
            shift_q <= BYTE_RST;
            oe_q <= 1'b0;
            ack_q <= 1'b0;
            acked_q <= 1'b0;
            halt_q <= 1'b0;
            pend_q <= 1'b0;
            wp_lock_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= BYTE_RST;
        end else if (st_q == D_PROG) begin
            // Deaf to the bus, so no acknowledge
            oe_q <= 1'b0;
            if (prog_done) begin
                st_q <= D_IDLE;
                addr_q <= addr_q + 1'b1;
            end
        end else if (start_det) begin
            st_q <= D_DEV;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
            ack_q <= 1'b0;
            acked_q <= 1'b0;
            halt_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (stop_det) begin
            oe_q <= 1'b0;
            ack_q <= 1'b0;
            pend_q <= 1'b0;
            if (st_q == D_WDATA && pend_q) begin
                st_q <= D_PROG;
                wp_lock_q <= wp_s_q[1];
            end else begin
                st_q <= D_IDLE;
            end
        end else if (st_q == D_RDATA) begin
            // Transmit after each falling edge
            if (scl_fall && !halt_q) begin
                if (bit_q < BIT_LAST) begin
                    shift_q <= {shift_q[6:0], 1'b0};
                    oe_q <= ~shift_q[6];
                    bit_q <= bit_q + 4'h1;
                end else if (bit_q == BIT_LAST) begin
                    oe_q <= 1'b0;
                    bit_q <= BIT_ACK;
                end else if (acked_q) begin
                    shift_q <= mem_q[addr_q];
                    oe_q <= ~mem_q[addr_q][7];
                    bit_q <= 4'h0;
                    acked_q <= 1'b0;
                end
            end
            if (scl_rise && bit_q == BIT_ACK && !halt_q && !acked_q) begin
                addr_q <= addr_q + 1'b1;
                if (sda_s) begin
                    halt_q <= 1'b1;
                end else begin
                    acked_q <= 1'b1;
                end
            end
        end else if (st_q != D_IDLE) begin
            // Receive on rises, answer in the ninth clock
            if (scl_rise && bit_q < BIT_ACK) begin
                shift_q <= {shift_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == BIT_ACK) begin
                if (ack_q) begin
                    ack_q <= 1'b0;
                    oe_q <= 1'b0;
                    bit_q <= 4'h0;
                    st_q <= nxt_q;
                    if (nxt_q == D_RDATA) begin
                        shift_q <= mem_q[addr_q];
                        oe_q <= ~mem_q[addr_q][7];
                    end
                end else begin
                    unique case (st_q)
                        D_DEV: begin
                            if (shift_q[7:TYPE_POS] == TYPE_CODE) begin
                                ack_q <= 1'b1;
                                oe_q <= 1'b1;
                                addr_q[AW-1:8] <= shift_q[AW-8:1];
                                nxt_q <= shift_q[RW_POS] ? D_RDATA : D_ADRH;
                            end else begin
                                st_q <= D_IDLE;
                            end
                        end
                        D_ADRH: begin
                            ack_q <= 1'b1;
                            oe_q <= 1'b1;
                            nxt_q <= D_ADRL;
                        end
                        D_ADRL: begin
                            addr_q[7:0] <= shift_q;
                            ack_q <= 1'b1;
                            oe_q <= 1'b1;
                            nxt_q <= D_WDATA;
                        end
                        D_WDATA: begin
                            wdata_q <= shift_q;
                            pend_q <= 1'b1;
                            ack_q <= 1'b1;
                            oe_q <= 1'b1;
                            nxt_q <= D_WDATA;
                        end
                        default: begin
                            st_q <= D_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule

/* test/see_link_asserts.sv */
// Checker for both ends of the two-wire bus
module see_link_asserts #(
    parameter int PROG_CYCLES = see_pkg::PROG_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic sda_line,
    input wire logic prog_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    import see_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic scl_q, sda_q, rd_q, ack_q, halt_q;
    logic [3:0] bit_q, since_stop_q;
    logic [1:0] widx_q;
    logic [7:0] word_q;
    int busy_cnt_q;
    wire logic scl_rise = scl & ~scl_q;
    wire logic start_ev = scl & scl_q & sda_q & ~sda_line;
    wire logic stop_ev = scl & scl_q & ~sda_q & sda_line;

    // Line history and counters
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            since_stop_q <= 4'hF;
            busy_cnt_q <= 0;
        end else begin
            scl_q <= scl;
            sda_q <= sda_line;
            since_stop_q <= stop_ev ? 4'h0 : since_stop_q + {3'h0, since_stop_q != 4'hF};
            busy_cnt_q <= prog_busy ? busy_cnt_q + 1 : 0;
        end
    end

    // Bit, word, direction and halt since the last start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 4'h0;
            widx_q <= 2'h0;
            word_q <= 8'h00;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            halt_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            bit_q <= 4'h0;
            widx_q <= 2'h0;
            halt_q <= 1'b0;
        end else if (scl_rise) begin
            bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
            if (bit_q < BIT_ACK && widx_q == 2'h0) word_q <= {word_q[6:0], sda_line};
            if (bit_q == BIT_LAST && widx_q == 2'h0) rd_q <= sda_line;
            if (bit_q == BIT_ACK && widx_q == 2'h0) ack_q <= ~sda_line;
            if (bit_q == BIT_ACK && widx_q != 2'h3) widx_q <= widx_q + 2'h1;
            if (bit_q == BIT_ACK && widx_q != 2'h0 && rd_q && sda_line) halt_q <= 1'b1;
        end
    end

    sequence s_ninth;
        scl_rise && bit_q == BIT_ACK;
    endsequence
    sequence s_addr_done;
        s_ninth ##0 widx_q == 2'h0;
    endsequence
    property p_open_drain; !(sda_d_oe && sda_d_o) && !(sda_m_oe && sda_m_o); endproperty
    property p_drive_scl_low; $rose(sda_d_oe) |-> !scl && !$past(scl, 2); endproperty
    property p_type_ack;
        s_addr_done |-> sda_line == !(word_q[7:TYPE_POS] == TYPE_CODE && !prog_busy);
    endproperty
    property p_write_ack; s_ninth ##0 (widx_q != 2'h0 && !rd_q && ack_q) |-> !sda_line; endproperty
    property p_read_release; s_ninth ##0 (widx_q != 2'h0 && rd_q) |-> !sda_d_oe; endproperty
    property p_halt_quiet; halt_q |-> !sda_d_oe; endproperty
    property p_busy_quiet; prog_busy |-> !sda_d_oe; endproperty
    property p_busy_len;
        $fell(prog_busy) |-> busy_cnt_q <= PROG_CYCLES && busy_cnt_q >= PROG_CYCLES - 1;
    endproperty
    property p_prog_after_stop; $rose(prog_busy) |-> since_stop_q <= 4'h6; endproperty
    property p_host_sda; $changed(sda_m_oe) && scl |-> start_ev || stop_ev; endproperty
    a_open_drain: assert property (p_open_drain) else $error("device drives sda high");
    a_drive_scl_low: assert property (p_drive_scl_low) else $error("pull not after fall");
    a_type_ack: assert property (p_type_ack) else $error("address word ack wrong");
    a_write_ack: assert property (p_write_ack) else $error("write byte not acked");
    a_read_release: assert property (p_read_release) else $error("sda held in ack slot");
    a_halt_quiet: assert property (p_halt_quiet) else $error("data sent after no-ack");
    a_busy_quiet: assert property (p_busy_quiet) else $error("bus driven while busy");
    a_busy_len: assert property (p_busy_len) else $error("programming length wrong");
    a_prog_after_stop: assert property (p_prog_after_stop) else $error("no stop first");
    a_host_sda: assert property (p_host_sda) else $error("host sda moved, scl high");
endmodule

/* test/serial_eeprom_bus_slave_tb_top.sv */
// Bench joining host end and device end over the two-wire link
module serial_eeprom_bus_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import see_pkg::*;
    localparam int PROG_TB = 4000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wp = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = 11'h000;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] cmd_len = 8'h00;
    logic rd_ready = 1'b0;
    logic cmd_ready, rd_valid, done, nack, prog_busy, saw_nack;
    logic [7:0] rd_data;
    logic [7:0] exp_mem [0:MEM_BYTES-1];
    logic [7:0] dat [4];
    logic [7:0] got_q [$];
    logic [ADDR_W-1:0] base;
    int seed = 23368;
    int n_mismatch = 0;
    int tests_run = 0;

    // System clock and the two ends
    always #4 clk_sys = ~clk_sys;
    see_bus_if bus_if ();
    see_dev_end #(.PROG_CYCLES(PROG_TB), .MEM_DEPTH(MEM_BYTES)) u_see_dev_end (.clk_sys(clk_sys),
        .rst_n(rst_n), .bus(bus_if.device), .wp(wp), .prog_busy(prog_busy));
    see_host_end #(.QTR_CYC(SCL_QTR_CYC), .RBUF_DEPTH(2)) u_see_host_end (.clk_sys(clk_sys),
        .rst_n(rst_n), .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_len(cmd_len),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .nack(nack));
    see_link_asserts #(.PROG_CYCLES(PROG_TB)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
        .scl(bus_if.scl), .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe),
        .sda_d_o(bus_if.sda_d_o), .sda_d_oe(bus_if.sda_d_oe), .sda_line(bus_if.sda_line),
        .prog_busy(prog_busy));

    // Collect popped read bytes
    always @(posedge clk_sys) if (rd_valid === 1'b1 && rd_ready) got_q.push_back(rd_data);

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    // Expected byte after a write; the protected half keeps its old value
    function automatic logic [7:0] after_write(input logic prot, input logic [ADDR_W-1:0] a,
                                               input logic [7:0] old, input logic [7:0] d);
        return (prot && a[ADDR_W-1]) ? old : d;
    endfunction

    task automatic run_cmd(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                           input logic [7:0] len);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_len = len;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        saw_nack = 1'b0;
        do begin
            @(posedge clk_sys);
            if (nack === 1'b1) saw_nack = 1'b1;
        end while (done !== 1'b1);
    endtask

    // Byte write, then wait out programming
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic ex_nack);
        run_cmd(1'b0, a, d, 8'h00);
        chk_flag(saw_nack, ex_nack);
        if (!ex_nack) exp_mem[a] = after_write(wp, a, exp_mem[a], d);
        repeat (8) @(posedge clk_sys);
        while (prog_busy !== 1'b0) @(posedge clk_sys);
    endtask

    // Writes, busy refusal, protection, stalled sequential read
    initial begin
        int k;
        base = 11'h400 | (11'($random(seed)) & 11'h1FC);
        foreach (dat[j]) dat[j] = 8'($random(seed));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        run_cmd(1'b0, base, dat[0], 8'h00);
        exp_mem[base] = dat[0];
        chk_flag(saw_nack, 1'b0);
        wr(base + 11'h001, dat[1], 1'b1);
        wr(base + 11'h001, dat[1], 1'b0);
        wr(base + 11'h002, dat[2], 1'b0);
        @(negedge clk_sys);
        wp = 1'b1;
        wr(base + 11'h002, dat[3], 1'b0);
        fork
            run_cmd(1'b1, base, 8'h00, 8'h02);
            begin
                while (rd_valid !== 1'b1) @(posedge clk_sys);
                repeat (8000) @(posedge clk_sys);
                chk_flag(bus_if.scl, 1'b0);
                @(negedge clk_sys);
                rd_ready = 1'b1;
            end
        join
        chk_flag(saw_nack, 1'b0);
        chk_byte(8'(got_q.size()), 8'h03);
        for (k = 0; k < 3; k++) chk_byte(got_q[k], exp_mem[base + 11'(k)]);
        final_report();
    end

    // Watchdog cuts a hung run short
    initial begin
        repeat (110000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end
endmodule
